// ### core/dgr_global_ctrl.sv
// Operation
// - run bit low: reset, hold, outputs off
// - run bit high: machines run, outputs on
// - autostart set: written run bit ignored
// - autostart, reset pin low: run bit cleared
// - no autostart: stay stopped until run written
// - autostart: run as reset pin rises
// - action field picks set-pin effect
// - 000 all, 011 loop, 100 machines+loop reset
// - 001 blue or colour, flywheel machines
// - 010 outputs hi-z, lock to input
// - 101 blue output, lock to input
// - 110 set pulse triggers line/pixel grab
// - 111 each pulse toggles normal/010 behaviour
// - after reset first toggle enters 010
// - sync disable bit blanks decoded syncs
// - two-bit video standard select field
// - grab bits 4 and 0 enable grabs
`timescale 1ns/1ps
`default_nettype none
`include "dgr_params.svh"

module dgr_global_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`DGR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rst_pin_n,
	input wire logic set_pin_n,
	input wire logic rgb_mode,
	input wire logic hsync_in,
	input wire logic vsync_in,
	output var dgr_pkg::dgr_ctl_s ctl,
	output logic decoded_hsync_out,
	output logic decoded_vsync_out,
	output logic [1:0] video_standard_select,
	output logic line_grab_pulse,
	output logic pixel_grab_pulse
);

	////////////////////////////////////////////////////////////////////////
	dgr_pkg::dgr_pins_s pins;
	dgr_pkg::dgr_pins_s pin_lvl;
	dgr_pkg::dgr_pins_s pin_fall;

	always_comb begin
		pins.rst_n = rst_pin_n;
		pins.set_n = set_pin_n;
	end

	dgr_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pins(pins),
		.lvl(pin_lvl),
		.fall(pin_fall)
	);

	////////////////////////////////////////////////////////////////////////
	logic soft_run_bit_reg;
	logic pin_reset_autostart_reg;
	dgr_pkg::dgr_action_e action_reg;
	logic sync_out_disable_reg;
	logic [7:0] grab_control_reg;
	dgr_pkg::dgr_tog_e tog_reg;
	dgr_pkg::dgr_tog_e tog_next;
	dgr_pkg::dgr_ctl_s ctl_next;
	logic [31:0] rdata_next;
	logic addr_ok;
	logic apb_wr;
	logic wr_gc;
	logic wr_gr;
	logic set_low;
	logic set_edge;

	function automatic logic is_act(input dgr_pkg::dgr_action_e a, input dgr_pkg::dgr_action_e c);
		is_act = (a == c);
	endfunction

	always_comb begin
		addr_ok = (paddr == `DGR_OFF_GLOBAL_CONTROL) || (paddr == `DGR_OFF_GRAB_CONTROL)
			|| (paddr == `DGR_OFF_STATUS);
		apb_wr = psel && penable && pready && pwrite && !pslverr;
		wr_gc = apb_wr && (paddr == `DGR_OFF_GLOBAL_CONTROL);
		wr_gr = apb_wr && (paddr == `DGR_OFF_GRAB_CONTROL);
		set_low = !pin_lvl.set_n && soft_run_bit_reg;
		set_edge = pin_fall.set_n && soft_run_bit_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// apb: answer loaded in setup, one access cycle, no wait states
	always_comb begin
		rdata_next = 32'h0;
		case (paddr)
			`DGR_OFF_GLOBAL_CONTROL: begin
				rdata_next[7:0] = {soft_run_bit_reg, pin_reset_autostart_reg, action_reg,
					sync_out_disable_reg, video_standard_select};
			end
			`DGR_OFF_GRAB_CONTROL: begin
				rdata_next[7:0] = grab_control_reg;
			end
			`DGR_OFF_STATUS: begin
				rdata_next[3:0] = {tog_reg == dgr_pkg::DGR_TOG_HELD, !pin_lvl.set_n,
					!pin_lvl.rst_n, soft_run_bit_reg};
			end
			default: begin
				rdata_next = 32'h0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (psel && !penable) begin
				prdata <= rdata_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// run bit: pin low always clears it; autostart overrides software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_run_bit_reg <= 1'(`DGR_GC_RESET >> `DGR_GC_RUN_BIT);
		end else if (!pin_lvl.rst_n) begin
			soft_run_bit_reg <= 1'b0;
		end else if (pin_reset_autostart_reg) begin
			soft_run_bit_reg <= 1'b1;
		end else if (wr_gc) begin
			soft_run_bit_reg <= pwdata[`DGR_GC_RUN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_reset_autostart_reg <= 1'b0;
			action_reg <= dgr_pkg::DGR_ACT_RESET_ALL;
			sync_out_disable_reg <= 1'b0;
			video_standard_select <= 2'h0;
		end else if (wr_gc) begin
			pin_reset_autostart_reg <= pwdata[`DGR_GC_AUTOSTART_BIT];
			action_reg <= dgr_pkg::dgr_action_e'(pwdata[`DGR_GC_ACTION_HI:`DGR_GC_ACTION_LO]);
			sync_out_disable_reg <= pwdata[`DGR_GC_SYNC_DIS_BIT];
			// code 01 is stored as written; the host must avoid it
			video_standard_select <= pwdata[`DGR_GC_VSTD_HI:`DGR_GC_VSTD_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grab_control_reg <= `DGR_GR_RESET;
		end else if (wr_gr) begin
			grab_control_reg <= pwdata[7:0] & `DGR_GR_WMASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// toggle state; any stop returns it to normal so next pulse holds
	always_comb begin
		tog_next = tog_reg;
		case (tog_reg)
			dgr_pkg::DGR_TOG_NORMAL: begin
				if (set_edge && is_act(action_reg, dgr_pkg::DGR_ACT_TOGGLE)) begin
					tog_next = dgr_pkg::DGR_TOG_HELD;
				end
			end
			dgr_pkg::DGR_TOG_HELD: begin
				if (set_edge && is_act(action_reg, dgr_pkg::DGR_ACT_TOGGLE)) begin
					tog_next = dgr_pkg::DGR_TOG_NORMAL;
				end
			end
			default: begin
				tog_next = dgr_pkg::DGR_TOG_NORMAL;
			end
		endcase
		if (!soft_run_bit_reg || !is_act(action_reg, dgr_pkg::DGR_ACT_TOGGLE)) begin
			tog_next = dgr_pkg::DGR_TOG_NORMAL;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_reg <= dgr_pkg::DGR_TOG_NORMAL;
		end else begin
			tog_reg <= tog_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// level actions last while the synchronised set pin stays low
	always_comb begin
		logic a0;
		logic a1;
		logic a2;
		logic a3;
		logic a4;
		logic a5;
		logic tg;
		a0 = set_low && is_act(action_reg, dgr_pkg::DGR_ACT_RESET_ALL);
		a1 = set_low && is_act(action_reg, dgr_pkg::DGR_ACT_BLUE_FLY);
		a2 = set_low && is_act(action_reg, dgr_pkg::DGR_ACT_HOLD_LOCK);
		a3 = set_low && is_act(action_reg, dgr_pkg::DGR_ACT_RESET_BLL);
		a4 = set_low && is_act(action_reg, dgr_pkg::DGR_ACT_RESET_SM);
		a5 = set_low && is_act(action_reg, dgr_pkg::DGR_ACT_BLUE_LOCK);
		tg = (tog_reg == dgr_pkg::DGR_TOG_HELD);
		ctl_next.out_hiz = !soft_run_bit_reg || a0 || a2 || tg;
		ctl_next.sm_reset = !soft_run_bit_reg || a0 || a4;
		ctl_next.bll_reset = !soft_run_bit_reg || a0 || a3 || a4;
		ctl_next.force_blue = (a1 && rgb_mode) || a5;
		ctl_next.force_colour = a1 && !rgb_mode;
		ctl_next.flywheel = a1;
		ctl_next.lock_ext = a2 || a5 || tg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= 7'h7F;
		end else begin
			ctl <= ctl_next;
		end
	end

	// grabs fire once per falling edge, gated by the grab enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_grab_pulse <= 1'b0;
			pixel_grab_pulse <= 1'b0;
		end else begin
			line_grab_pulse <= set_edge && is_act(action_reg, dgr_pkg::DGR_ACT_GRAB)
				&& grab_control_reg[`DGR_GR_LINE_EXT_BIT];
			pixel_grab_pulse <= set_edge && is_act(action_reg, dgr_pkg::DGR_ACT_GRAB)
				&& grab_control_reg[`DGR_GR_PIXEL_EXT_BIT];
		end
	end

	// syncs also drop while outputs are off, so no stray edges leave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decoded_hsync_out <= 1'b0;
			decoded_vsync_out <= 1'b0;
		end else begin
			decoded_hsync_out <= hsync_in && !sync_out_disable_reg && !ctl_next.out_hiz;
			decoded_vsync_out <= vsync_in && !sync_out_disable_reg && !ctl_next.out_hiz;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_stop_holds;
		@(posedge pclk) disable iff (!presetn)
		!soft_run_bit_reg |=> ctl.sm_reset && ctl.out_hiz && ctl.bll_reset;
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("stopped but not held");

	property p_run_frees;
		@(posedge pclk) disable iff (!presetn)
		soft_run_bit_reg && pin_lvl.set_n && tog_reg == dgr_pkg::DGR_TOG_NORMAL
			|=> !ctl.sm_reset && !ctl.out_hiz;
	endproperty
	a_run_frees: assert property (p_run_frees) else $error("running but held");

	property p_auto_ignores;
		@(posedge pclk) disable iff (!presetn)
		wr_gc && pin_reset_autostart_reg && !pwdata[`DGR_GC_RUN_BIT]
			|=> soft_run_bit_reg == $past(pin_lvl.rst_n);
	endproperty
	a_auto_ignores: assert property (p_auto_ignores) else $error("run write obeyed");

	property p_pin_clears;
		@(posedge pclk) disable iff (!presetn)
		!pin_lvl.rst_n |=> !soft_run_bit_reg ##1 ctl.sm_reset;
	endproperty
	a_pin_clears: assert property (p_pin_clears) else $error("pin reset missed");

	property p_wait_write;
		@(posedge pclk) disable iff (!presetn)
		!soft_run_bit_reg && !pin_reset_autostart_reg && !wr_gc |=> !soft_run_bit_reg;
	endproperty
	a_wait_write: assert property (p_wait_write) else $error("started unasked");

	property p_auto_start;
		@(posedge pclk) disable iff (!presetn)
		pin_reset_autostart_reg && pin_lvl.rst_n && !$past(pin_lvl.rst_n) |=> soft_run_bit_reg;
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("autostart late");

	property p_reset_all;
		@(posedge pclk) disable iff (!presetn)
		set_low && action_reg == dgr_pkg::DGR_ACT_RESET_ALL
			|=> ctl.out_hiz && ctl.sm_reset && ctl.bll_reset;
	endproperty
	a_reset_all: assert property (p_reset_all) else $error("action 000 missing");

	property p_grab;
		@(posedge pclk) disable iff (!presetn)
		set_edge && action_reg == dgr_pkg::DGR_ACT_GRAB
			|=> line_grab_pulse == $past(grab_control_reg[`DGR_GR_LINE_EXT_BIT]) ##1 !line_grab_pulse;
	endproperty
	a_grab: assert property (p_grab) else $error("grab pulse wrong");

	property p_toggle;
		@(posedge pclk) disable iff (!presetn)
		set_edge && action_reg == dgr_pkg::DGR_ACT_TOGGLE && $stable(action_reg)
			|=> tog_reg != $past(tog_reg) ##1 ctl.lock_ext == ($past(tog_reg) == dgr_pkg::DGR_TOG_HELD);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missed");

	property p_sync_off;
		@(posedge pclk) disable iff (!presetn)
		sync_out_disable_reg |=> !decoded_hsync_out && !decoded_vsync_out;
	endproperty
	a_sync_off: assert property (p_sync_off) else $error("sync not blanked");

endmodule

`default_nettype wire

// ### core/dgr_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "dgr_params.svh"

module dgr_pin_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire dgr_pkg::dgr_pins_s pins,
	output var dgr_pkg::dgr_pins_s lvl,
	output var dgr_pkg::dgr_pins_s fall
);

	dgr_pkg::dgr_pins_s meta_reg;
	dgr_pkg::dgr_pins_s prev_reg;

	// first stage feeds only the second; edges are taken after it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= `DGR_PINS_RESET;
			lvl <= `DGR_PINS_RESET;
		end else begin
			meta_reg <= pins;
			lvl <= meta_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= `DGR_PINS_RESET;
		end else begin
			prev_reg <= lvl;
		end
	end

	// high-to-low detect on the clean stage
	always_comb begin
		fall = prev_reg & ~lvl;
	end

endmodule

`default_nettype wire

// ### inc/dgr_params.svh
`ifndef DGR_PARAMS_SVH
`define DGR_PARAMS_SVH

// byte addresses on the apb bus
`define DGR_ADDR_W 12
`define DGR_OFF_GLOBAL_CONTROL 12'h000
`define DGR_OFF_GRAB_CONTROL 12'h030
`define DGR_OFF_STATUS 12'h080

// global_control fields
`define DGR_GC_RUN_BIT 7
`define DGR_GC_AUTOSTART_BIT 6
`define DGR_GC_ACTION_HI 5
`define DGR_GC_ACTION_LO 3
`define DGR_GC_SYNC_DIS_BIT 2
`define DGR_GC_VSTD_HI 1
`define DGR_GC_VSTD_LO 0
`define DGR_GC_RESET 8'h00

// grab_control_reg fields; bit 7 reads as zero
`define DGR_GR_LINE_EXT_BIT 4
`define DGR_GR_PIXEL_EXT_BIT 0
`define DGR_GR_WMASK 8'h7F
`define DGR_GR_RESET 8'h00

// pin synchroniser reset value, {reset pin, set pin}
`define DGR_PINS_RESET 2'h1

`endif

// ### inc/dgr_pkg.sv
`default_nettype none
package dgr_pkg;

	typedef enum logic [2:0] {
		DGR_ACT_RESET_ALL = 3'b000,
		DGR_ACT_BLUE_FLY = 3'b001,
		DGR_ACT_HOLD_LOCK = 3'b010,
		DGR_ACT_RESET_BLL = 3'b011,
		DGR_ACT_RESET_SM = 3'b100,
		DGR_ACT_BLUE_LOCK = 3'b101,
		DGR_ACT_GRAB = 3'b110,
		DGR_ACT_TOGGLE = 3'b111
	} dgr_action_e;

	typedef enum logic {
		DGR_TOG_NORMAL = 1'b0,
		DGR_TOG_HELD = 1'b1
	} dgr_tog_e;

	typedef struct packed {
		logic rst_n;
		logic set_n;
	} dgr_pins_s;

	typedef struct packed {
		logic out_hiz;
		logic sm_reset;
		logic bll_reset;
		logic force_blue;
		logic force_colour;
		logic flywheel;
		logic lock_ext;
	} dgr_ctl_s;

endpackage

`default_nettype wire

// ### testbench/dgr_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none
// far side of the pins: reset and set lines, changed just after an edge
module dgr_pin_drv (
	input wire logic pclk,
	output logic rst_pin_n,
	output logic set_pin_n
);
	initial begin
		rst_pin_n = 1'h0;
		set_pin_n = 1'h1;
	end
	////////////////////////////////////////////////////////////////
	task automatic drive(input logic r, input logic s);
		@(posedge pclk);
		rst_pin_n <= r;
		set_pin_n <= s;
	endtask
	// two low samples, then high long enough that the next fall is seen
	task automatic pulse();
		drive(rst_pin_n, 1'h0);
		drive(rst_pin_n, 1'h0);
		drive(rst_pin_n, 1'h1);
		drive(rst_pin_n, 1'h1);
	endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dgr_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module tb_top;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [`DGR_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, rst_pin_n, set_pin_n, hs_out, vs_out, lg_p, pg_p;
	logic rgb_mode = 1'h0;
	logic hsync_in = 1'h0;
	logic vsync_in = 1'h0;
	logic hs_prev = 1'h0;
	logic vs_prev = 1'h0;
	logic sync_on = 1'h0;
	logic sync_gate = 1'h0;
	dgr_pkg::dgr_ctl_s ctl;
	logic [1:0] vstd;
	logic [32:0] expq[$];
	logic [31:0] rnd = 32'hC38E0711;
	logic [7:0] gv[4] = '{8'h11, 8'h10, 8'h01, 8'h00};
	logic [1:0] sv[3] = '{2'h0, 2'h2, 2'h3};
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	int lg_cnt = 0;
	int pg_cnt = 0;
	int k, m;

	always #10 pclk = ~pclk;

	dgr_global_ctrl u_dgr_global_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rst_pin_n(rst_pin_n), .set_pin_n(set_pin_n),
		.rgb_mode(rgb_mode), .hsync_in(hsync_in), .vsync_in(vsync_in), .ctl(ctl),
		.decoded_hsync_out(hs_out), .decoded_vsync_out(vs_out),
		.video_standard_select(vstd), .line_grab_pulse(lg_p), .pixel_grab_pulse(pg_p));
	dgr_pin_drv u_dgr_pin_drv (.pclk(pclk), .rst_pin_n(rst_pin_n), .set_pin_n(set_pin_n));

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [6:0] act_exp(input logic [2:0] a);
		case (a)
			3'h0: return 7'h70;
			3'h1: return rgb_mode ? 7'h0A : 7'h06;
			3'h2: return 7'h41;
			3'h3: return 7'h10;
			3'h4: return 7'h30;
			default: return 7'h09;
		endcase
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// wait states allowed: the access phase lasts until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		if (!w) expq.push_back(e);
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'h1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		apb(1'h0, a, 8'h00, e);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	////////////////////////////////////////////////////////////////
	// result watcher: reads, grab pulses and the gated syncs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			end_of_test();
		end
		if (lg_p === 1'h1) lg_cnt++;
		if (pg_p === 1'h1) pg_cnt++;
		if (psel && penable && pready === 1'h1 && !pwrite && expq.size() > 0)
			`CHK({pslverr, prdata}, expq.pop_front())
		if (sync_on) `CHK({hs_out, vs_out}, {hs_prev, vs_prev} & {2{sync_gate}})
		hs_prev <= hsync_in;
		vs_prev <= vsync_in;
		rnd <= lfsr(rnd);
		hsync_in <= rnd[3];
		vsync_in <= rnd[9];
	end

	initial begin
		wt(2);
		presetn <= 1'h1;
		`CHK(ctl, 7'h7F)
		rd(`DGR_OFF_GLOBAL_CONTROL, {25'h0, `DGR_GC_RESET});
		rd(12'h004, 33'h100000000);
		u_dgr_pin_drv.drive(1'h1, 1'h1);
		wt(4);
		`CHK(ctl, 7'h70)
		wr(`DGR_OFF_GLOBAL_CONTROL, 8'h80);
		wt(3);
		`CHK(ctl, 7'h00)
		done("run");
		wr(`DGR_OFF_GLOBAL_CONTROL, 8'h40);
		// second write lands with autostart already set, so its run bit 0 is ignored
		wr(`DGR_OFF_GLOBAL_CONTROL, 8'h40);
		wt(3);
		rd(`DGR_OFF_GLOBAL_CONTROL, 33'hC0);
		u_dgr_pin_drv.drive(1'h0, 1'h1);
		wt(4);
		rd(`DGR_OFF_STATUS, 33'h02);
		`CHK(ctl, 7'h70)
		u_dgr_pin_drv.drive(1'h1, 1'h1);
		// pin to run bit takes three edges, run bit to ctl one more
		wt(5);
		`CHK(ctl, 7'h00)
		done("autostart");
		for (int i = 0; i < 6; i++) begin
			rgb_mode <= rnd[0];
			wr(`DGR_OFF_GLOBAL_CONTROL, 8'h80 | 8'(i * 8));
			u_dgr_pin_drv.drive(1'h1, 1'h0);
			wt(4);
			`CHK(ctl, act_exp(3'(i)))
			u_dgr_pin_drv.drive(1'h1, 1'h1);
			wt(4);
			`CHK(ctl, 7'h00)
		end
		done("actions");
		wr(`DGR_OFF_GLOBAL_CONTROL, 8'hB0);
		wr(`DGR_OFF_GRAB_CONTROL, 8'hFF);
		rd(`DGR_OFF_GRAB_CONTROL, {25'h0, `DGR_GR_WMASK});
		foreach (gv[j]) begin
			wr(`DGR_OFF_GRAB_CONTROL, gv[j]);
			k = lg_cnt;
			m = pg_cnt;
			u_dgr_pin_drv.pulse();
			wt(4);
			`CHK(lg_cnt - k, int'(gv[j][4]))
			`CHK(pg_cnt - m, int'(gv[j][0]))
		end
		done("grab");
		wr(`DGR_OFF_GLOBAL_CONTROL, 8'hB8);
		for (int i = 0; i < 3; i++) begin
			u_dgr_pin_drv.pulse();
			wt(4);
			`CHK(ctl, i[0] ? 7'h00 : 7'h41)
		end
		wr(`DGR_OFF_GLOBAL_CONTROL, 8'h38);
		wr(`DGR_OFF_GLOBAL_CONTROL, 8'hB8);
		u_dgr_pin_drv.pulse();
		wt(4);
		`CHK(ctl, 7'h41)
		rd(`DGR_OFF_STATUS, 33'h09);
		done("toggle");
		wr(`DGR_OFF_GLOBAL_CONTROL, 8'h80);
		wt(4);
		sync_gate <= 1'h1;
		sync_on <= 1'h1;
		wt(20);
		sync_on <= 1'h0;
		wr(`DGR_OFF_GLOBAL_CONTROL, 8'h84);
		wt(4);
		sync_gate <= 1'h0;
		sync_on <= 1'h1;
		wt(20);
		sync_on <= 1'h0;
		done("sync");
		// code 01 is left out on purpose, the host must never program it
		foreach (sv[j]) begin
			wr(`DGR_OFF_GLOBAL_CONTROL, {6'h20, sv[j]});
			wt(2);
			`CHK(vstd, sv[j])
			rd(`DGR_OFF_GLOBAL_CONTROL, {25'h0, 6'h20, sv[j]});
		end
		done("standard");
		presetn <= 1'h0;
		wt(2);
		`CHK(ctl, 7'h7F)
		presetn <= 1'h1;
		wt(3);
		`CHK(ctl, 7'h70)
		done("second reset");
		end_of_test();
	end
endmodule
`default_nettype wire
